// [hw/loader_pkg.sv]
// constants for the serial register loader
package loader_pkg;
    localparam int WORD_W = 32;
    localparam int LATCH_COUNT = 12;
    localparam int SEL_W = 5;
    localparam logic [4:0] SEL_POWER = 5'h00;
    localparam logic [4:0] SEL_MONITOR = 5'h03;
    localparam logic [4:0] SEL_COMMIT = 5'h05;
    localparam logic [4:0] SEL_FRACTION_NUMERATOR_LOW = 5'h06;
    localparam logic [4:0] SEL_REF = 5'h07;
    localparam logic [4:0] SEL_LIMIT = 5'h0c;
    localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
    // power and calibration control field positions
    localparam int POS_REF_CNT_PUP = 15;
    localparam int POS_FB_CNT_PUP = 14;
    localparam int POS_TX2_CAL = 12;
    localparam int POS_TX1_CAL = 11;
    localparam int POS_OSC_PUP = 10;
    localparam int POS_OSC_CAL = 9;
    localparam int POS_CONV_PUP = 8;
    localparam int POS_TX2_PUP = 7;
    localparam int POS_TX1_PUP = 6;
    localparam int POS_LO_PUP = 5;
    localparam int POS_AUX_GAIN_LSB = 21;
    localparam int AUX_GAIN_W = 3;
    // divider fields
    localparam int POS_INT_LSB = 17;
    localparam int INT_W = 12;
    localparam int POS_FRACTION_NUMERATOR_MSB_LSB = 5;
    localparam int FRACTION_NUMERATOR_MSB_W = 12;
    localparam int POS_FRACTION_NUMERATOR_LOW_LSB = 5;
    localparam int FRACTION_NUMERATOR_LOW_W = 13;
    localparam int FRACTION_NUMERATOR_W = 25;
    localparam logic [11:0] INT_MIN = 12'h04b;
    localparam logic [11:0] INT_MAX = 12'hfff;
    localparam int POS_REF_CNT_LSB = 5;
    localparam int REF_CNT_W = 5;
    localparam int POS_DOUBLER = 10;
    localparam int POS_HALVING = 11;
    localparam int POS_CLK_DIV_LSB = 12;
    localparam int CLK_DIV_W = 12;
    localparam int POS_MONITOR_LSB = 12;
    localparam int MONITOR_W = 4;
    localparam int SYNC_STAGES = 3;
endpackage

// [hw/pin_sync.sv]
// three-stage pin synchroniser with agreement filter and rise detect
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            level <= '0;
            rise <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level[i] <= s3_reg[i];
                end
                rise[i] <= (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !level[i];
            end
        end
    end
endmodule

// [hw/serial_register_loader.sv]
// serial register loader with latch bank, double buffering and power control
`timescale 1ns/1ps
// Operation
// RL1: serial data shifts into a 32-bit register on each serial clock rise.
// RL2: host sends words MSB first, select field arriving last.
// RL3: load strobe rise copies the shift register into one of twelve latches.
// RL4: the five lowest shifted bits pick the destination latch.
// RL5: select codes zero to eleven address latches zero to eleven.
// RL6: fraction low, reference count, doubler, divider, halving, monitor are staged.
// RL7: staged settings take effect only when register five is written.
// RL8: host writes fraction low bits to register six before register five.
// RL9: frequency change starts only after a register zero write.
// RL10: integer word is 12 bits, valid from 75 to 4095.
// RL11: 5-bit reference counter divides by 1 to 32.
// RL12: fraction numerator is held as a 25-bit unsigned value.
// RL13: output frequency is twice reference times integer plus fraction over 2^25.
// RL14: internal reference uses doubler and halving bits, each zero or one.
// RL15: register zero holds power-up bits, calibration triggers and fixed bits.
// RL16: chip enable low powers down; high follows the stored power-up bits.
// RL17: no strobe means no latch change; unlisted select codes are ignored.
module serial_register_loader (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    output logic [11:0] int_word,
    output logic [24:0] fraction_numerator,
    output logic [5:0] ref_ratio,
    output logic ref_doubler,
    output logic reference_halving_bit,
    output logic [11:0] clock_divider,
    output logic [3:0] monitor_output_select,
    output logic [2:0] aux_gain_field,
    output logic ref_counter_power_up,
    output logic feedback_counter_power_up,
    output logic oscillator_power_up,
    output logic converter_power_up,
    output logic transmitter_one_power_up,
    output logic transmitter_two_power_up,
    output logic local_osc_output_power_up,
    output logic oscillator_calibrate,
    output logic transmitter_one_amp_calibrate,
    output logic transmitter_two_amp_calibrate,
    output logic freq_change_start,
    output logic int_range_error
);
    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [31:0] shift_reg;
    logic [11:0][31:0] latch_reg;
    logic [4:0] sel;
    logic load_rise;
    logic sclk_rise;
    logic sdata;
    logic ce_level;
    logic [11:0] int_stage_reg;
    logic [24:0] fraction_numerator_stage_reg;
    logic [4:0] ref_cnt_act_reg;

    pin_sync #(.W(4)) u_pins (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in({chip_enable, load_strobe, serial_data, serial_clk}),
        .level(pin_level),
        .rise(pin_rise)
    );

    assign sclk_rise = pin_rise[0];
    assign sdata = pin_level[1];
    assign load_rise = pin_rise[2];
    assign ce_level = pin_level[3];
    assign sel = shift_reg[4:0]; // RL4

    // shift in MSB first, one bit per serial clock rise
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= loader_pkg::LATCH_RESET;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[30:0], sdata}; // RL1 RL2
        end
    end

    // latch bank write on load strobe rise
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_reg <= '{default: loader_pkg::LATCH_RESET};
        end else if (load_rise && sel < loader_pkg::SEL_LIMIT) begin // RL17
            latch_reg[sel] <= shift_reg; // RL3 RL5
        end
    end

    // staged settings adopted when register five is written
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_stage_reg <= '0;
            fraction_numerator_stage_reg <= '0;
            ref_cnt_act_reg <= '0;
            ref_doubler <= 1'b0;
            reference_halving_bit <= 1'b0;
            clock_divider <= '0;
            monitor_output_select <= '0;
        end else if (load_rise && sel == loader_pkg::SEL_COMMIT) begin // RL7
            int_stage_reg <= shift_reg[loader_pkg::POS_INT_LSB +: loader_pkg::INT_W];
            fraction_numerator_stage_reg <= {shift_reg[loader_pkg::POS_FRACTION_NUMERATOR_MSB_LSB +: loader_pkg::FRACTION_NUMERATOR_MSB_W],
                latch_reg[6][loader_pkg::POS_FRACTION_NUMERATOR_LOW_LSB +: loader_pkg::FRACTION_NUMERATOR_LOW_W]}; // RL6 RL12
            ref_cnt_act_reg <= latch_reg[7][loader_pkg::POS_REF_CNT_LSB +: loader_pkg::REF_CNT_W];
            ref_doubler <= latch_reg[7][loader_pkg::POS_DOUBLER]; // RL14
            reference_halving_bit <= latch_reg[7][loader_pkg::POS_HALVING];
            clock_divider <= latch_reg[7][loader_pkg::POS_CLK_DIV_LSB +: loader_pkg::CLK_DIV_W];
            monitor_output_select <= latch_reg[3][loader_pkg::POS_MONITOR_LSB +:
                loader_pkg::MONITOR_W]; // RL6
        end
    end

    // a stored count of zero divides by 32
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_ratio <= 6'h20;
        end else begin
            ref_ratio <= (ref_cnt_act_reg == 5'h00) ? 6'h20 : {1'b0, ref_cnt_act_reg}; // RL11
        end
    end

    // divider words applied to the synthesiser only on a register zero write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_word <= '0;
            fraction_numerator <= '0;
            freq_change_start <= 1'b0;
            int_range_error <= 1'b0;
        end else begin
            freq_change_start <= load_rise && sel == loader_pkg::SEL_POWER; // RL9
            if (load_rise && sel == loader_pkg::SEL_POWER) begin
                int_word <= int_stage_reg; // RL13
                fraction_numerator <= fraction_numerator_stage_reg;
                int_range_error <= int_stage_reg < loader_pkg::INT_MIN; // RL10
            end
        end
    end

    // power-up outputs follow chip enable and register zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_counter_power_up <= 1'b0;
            feedback_counter_power_up <= 1'b0;
            oscillator_power_up <= 1'b0;
            converter_power_up <= 1'b0;
            transmitter_one_power_up <= 1'b0;
            transmitter_two_power_up <= 1'b0;
            local_osc_output_power_up <= 1'b0;
            aux_gain_field <= '0;
        end else begin
            ref_counter_power_up <= ce_level && latch_reg[0][loader_pkg::POS_REF_CNT_PUP]; // RL16
            feedback_counter_power_up <= ce_level && latch_reg[0][loader_pkg::POS_FB_CNT_PUP];
            oscillator_power_up <= ce_level && latch_reg[0][loader_pkg::POS_OSC_PUP]; // RL15
            converter_power_up <= ce_level && latch_reg[0][loader_pkg::POS_CONV_PUP];
            transmitter_one_power_up <= ce_level && latch_reg[0][loader_pkg::POS_TX1_PUP];
            transmitter_two_power_up <= ce_level && latch_reg[0][loader_pkg::POS_TX2_PUP];
            local_osc_output_power_up <= ce_level && latch_reg[0][loader_pkg::POS_LO_PUP];
            aux_gain_field <= latch_reg[0][loader_pkg::POS_AUX_GAIN_LSB +: loader_pkg::AUX_GAIN_W];
        end
    end

    // calibration triggers pulse once per register zero write that sets their bit
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            oscillator_calibrate <= 1'b0;
            transmitter_one_amp_calibrate <= 1'b0;
            transmitter_two_amp_calibrate <= 1'b0;
        end else begin
            oscillator_calibrate <= load_rise && sel == loader_pkg::SEL_POWER
                && shift_reg[loader_pkg::POS_OSC_CAL]; // RL15
            transmitter_one_amp_calibrate <= load_rise && sel == loader_pkg::SEL_POWER
                && shift_reg[loader_pkg::POS_TX1_CAL];
            transmitter_two_amp_calibrate <= load_rise && sel == loader_pkg::SEL_POWER
                && shift_reg[loader_pkg::POS_TX2_CAL];
        end
    end

    a_shift_msb_first: assert property (@(posedge core_clk) disable iff (!reset_n) // RL1
        sclk_rise |=> shift_reg == {$past(shift_reg[30:0]), $past(sdata)})
        else $error("shift register did not take the data bit");
    a_latch_selected: assert property (@(posedge core_clk) disable iff (!reset_n) // RL3
        load_rise && sel < loader_pkg::SEL_LIMIT |=> latch_reg[$past(sel)] == $past(shift_reg))
        else $error("selected latch not loaded");
    a_no_strobe_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // RL17
        !load_rise |=> $stable(latch_reg))
        else $error("latch changed without a load strobe");
    a_unlisted_ignored: assert property (@(posedge core_clk) disable iff (!reset_n) // RL5
        load_rise && sel >= loader_pkg::SEL_LIMIT |=> $stable(latch_reg))
        else $error("unlisted select code changed a latch");
    a_fraction_numerator_staged: assert property (@(posedge core_clk) disable iff (!reset_n) // RL7
        !(load_rise && sel == loader_pkg::SEL_COMMIT) |=> $stable(fraction_numerator_stage_reg)
        && $stable(ref_cnt_act_reg) && $stable(monitor_output_select))
        else $error("staged setting moved without a register five write");
    a_freq_on_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // RL9
        freq_change_start == $past(load_rise && sel == loader_pkg::SEL_POWER)
        && (freq_change_start || $stable(int_word)))
        else $error("frequency change outside a register zero write");
    a_shift_quiet: assert property (@(posedge core_clk) disable iff (!reset_n) // RL1
        !sclk_rise |=> $stable(shift_reg))
        else $error("shift register moved without a serial clock rise");
    a_commit_adopts: assert property (@(posedge core_clk) disable iff (!reset_n) // RL6
        load_rise && sel == loader_pkg::SEL_COMMIT |=> ref_cnt_act_reg
        == $past(latch_reg[7][loader_pkg::POS_REF_CNT_LSB +: loader_pkg::REF_CNT_W]))
        else $error("staged reference count not adopted on register five write");
    a_power_follows: assert property (@(posedge core_clk) disable iff (!reset_n) // RL15
        ce_level |=> oscillator_power_up == $past(latch_reg[0][loader_pkg::POS_OSC_PUP]))
        else $error("oscillator power bit does not follow register zero");
    a_cal_single: assert property (@(posedge core_clk) disable iff (!reset_n) // RL15
        oscillator_calibrate |=> !oscillator_calibrate)
        else $error("calibration trigger longer than one cycle");
    a_int_range: assert property (@(posedge core_clk) disable iff (!reset_n) // RL10
        freq_change_start |-> int_range_error == (int_word < loader_pkg::INT_MIN))
        else $error("integer range flag wrong");
    a_ref_ratio_bound: assert property (@(posedge core_clk) disable iff (!reset_n) // RL11
        ##1 ref_ratio >= 6'h01 && ref_ratio <= 6'h20)
        else $error("reference ratio out of range");
    a_ce_power_down: assert property (@(posedge core_clk) disable iff (!reset_n) // RL16
        !ce_level |=> !oscillator_power_up && !ref_counter_power_up && !transmitter_one_power_up)
        else $error("block powered while chip enable low");
endmodule

// [tb/host_model.sv]
// host model driving the three-wire serial write port
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // each pin level stands four core cycles, above the two the port needs
    task automatic write_word(input logic [31:0] w, input logic strobe);
        // register zero carries fixed ones that the host must always send
        if (w[4:0] == 5'h00) begin
            w = w | 32'h800f_2000;
        end
        for (int i = 31; i >= 0; i--) begin
            serial_data = w[i];
            hold(4);
            serial_clk = 1'b1;
            hold(4);
            serial_clk = 1'b0;
        end
        serial_data = ~w[0];
        load_strobe = strobe;
        hold(4);
        load_strobe = 1'b0;
        hold(8);
    endtask
endmodule

// [tb/tb_serial_register_loader.sv]
// self-checking bench for the serial register loader
`timescale 1ns/1ps
module tb_serial_register_loader;
    typedef struct {logic [31:0] w; logic ce; logic [6:0] pup; logic [2:0] aux;} row_s;
    logic core_clk, reset_n, chip_enable, serial_clk, serial_data, load_strobe;
    logic [11:0] int_word, clock_divider;
    logic [24:0] fraction_numerator;
    logic [5:0] ref_ratio;
    logic ref_doubler, reference_halving_bit, freq_change_start, int_range_error;
    logic [3:0] monitor_output_select;
    logic [2:0] aux_gain_field, cal;
    logic [6:0] pup;
    int bad_count = 0, samples_checked = 0, cycles = 0, starts = 0;
    int cals[3] = '{0, 0, 0};
    row_s rows[4] = '{'{32'h00a0_c000, 1'b1, 7'h60, 3'h5}, '{32'h0000_05e0, 1'b1, 7'h1f, 3'h0},
        '{32'h00e0_c5e0, 1'b0, 7'h00, 3'h7}, '{32'h00e0_c5e0, 1'b1, 7'h7f, 3'h7}};
    host_model host_model_i (.core_clk(core_clk), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe));
    serial_register_loader serial_register_loader_i (.core_clk(core_clk), .reset_n(reset_n),
        .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe),
        .chip_enable(chip_enable), .int_word(int_word), .fraction_numerator(fraction_numerator),
        .ref_ratio(ref_ratio), .ref_doubler(ref_doubler),
        .reference_halving_bit(reference_halving_bit), .clock_divider(clock_divider),
        .monitor_output_select(monitor_output_select), .aux_gain_field(aux_gain_field),
        .ref_counter_power_up(pup[6]), .feedback_counter_power_up(pup[5]),
        .oscillator_power_up(pup[4]), .converter_power_up(pup[3]),
        .transmitter_two_power_up(pup[2]), .transmitter_one_power_up(pup[1]),
        .local_osc_output_power_up(pup[0]), .oscillator_calibrate(cal[0]),
        .transmitter_one_amp_calibrate(cal[1]), .transmitter_two_amp_calibrate(cal[2]),
        .freq_change_start(freq_change_start), .int_range_error(int_range_error));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic final_report();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // pulse counters and run ceiling
    always @(negedge core_clk) begin
        cycles++;
        if (freq_change_start === 1'b1) begin
            starts++;
        end
        for (int k = 0; k < 3; k++) begin
            if (cal[k] === 1'b1) begin
                cals[k]++;
            end
        end
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        reset_n = 1'b0;
        chip_enable = 1'b1;
        repeat (16) @(negedge core_clk);
        check(ref_ratio, 32'h20);
        check(int_word, 32'h0);
        reset_n = 1'b1;
        foreach (rows[r]) begin
            chip_enable = rows[r].ce;
            host_model_i.write_word(rows[r].w, 1'b1);
            check(pup, rows[r].pup);
            check(aux_gain_field, rows[r].aux);
            check(starts, r + 1);
        end
        host_model_i.write_word(32'h0000_1a00, 1'b1);
        foreach (cals[k]) check(cals[k], 32'h1);
        host_model_i.write_word(32'h00ab_cc67, 1'b1);
        host_model_i.write_word(32'h0000_9003, 1'b1);
        host_model_i.write_word(32'h0002_4686, 1'b1);
        check(ref_ratio, 32'h20);
        check(monitor_output_select, 32'h0);
        host_model_i.write_word(32'h00c9_3565, 1'b1);
        check(ref_ratio, 32'h3);
        check({ref_doubler, reference_halving_bit, clock_divider, monitor_output_select},
            {2'b11, 12'habc, 4'h9});
        check(int_word, 32'h0);
        host_model_i.write_word(32'h0000_0000, 1'b1);
        check(int_word, 32'h064);
        check(fraction_numerator, {12'h9ab, 13'h1234});
        check(int_range_error, 32'h0);
        host_model_i.write_word(32'h0094_0005, 1'b1);
        host_model_i.write_word(32'h0000_0000, 1'b1);
        check(int_range_error, 32'h1);
        check(fraction_numerator, {12'h000, 13'h1234});
        host_model_i.write_word(32'h0096_0005, 1'b1);
        host_model_i.write_word(32'h0000_0000, 1'b1);
        check(int_range_error, 32'h0);
        host_model_i.write_word(32'h00c9_356c, 1'b1);
        host_model_i.write_word(32'h00c9_3565, 1'b0);
        host_model_i.write_word(32'h0000_0000, 1'b1);
        check(int_word, 32'h04b);
        check(starts, 32'h9);
        reset_n = 1'b0;
        @(negedge core_clk);
        check(int_word, 32'h0);
        check(ref_ratio, 32'h20);
        reset_n = 1'b1;
        host_model_i.write_word(32'h0000_0000, 1'b1);
        check(int_word, 32'h0);
        check(int_range_error, 32'h1);
        check(starts, 32'ha);
        final_report();
    end
endmodule
